/* File: tbd_pkg.sv */
// Shared types and constants for the trace bucket detector.
// Summary of operation
// - Sample mode outputs the bucket midpoint sample.
// - Trace points configurable from 1 to 40001.
// - Positive peak outputs bucket maximum.
// - Negative peak outputs bucket minimum.
// - Normal mode: rose and fell means noise.
// - Even noise bucket: output minimum, remember maximum.
// - Odd noise bucket: output larger of maxima.
// - One-direction bucket always outputs its maximum.
// - Average mode combines every bucket sample.
// - Averaging type selects power, voltage or log.
// - Power: rms of samples, power over impedance.
// - Voltage: mean of linear envelope samples.
// - Log: mean of decibel-scaled samples.
// - Bucket length is sweep over points minus one.
package tbd_pkg;

	localparam int unsigned TBD_SAMPLE_W      = 16;
	localparam int unsigned TBD_POINT_W       = 16;
	localparam int unsigned TBD_CNT_W         = 16;
	localparam int unsigned TBD_ACC_W         = 2 * TBD_SAMPLE_W + TBD_CNT_W;
	localparam int unsigned TBD_MAX_POINTS    = 40001;
	localparam int unsigned TBD_MIN_POINTS    = 1;
	localparam logic [TBD_CNT_W-1:0] TBD_IMPEDANCE_OHM = 16'h0032;
	localparam logic [TBD_SAMPLE_W-1:0] TBD_LOWEST_AMP = 16'h0000;
	localparam logic [TBD_POINT_W-1:0] TBD_FIRST_BUCKET = 16'h0001;

	typedef enum logic [2:0]
	{
		TBD_DET_SAMPLE  = 3'h0,
		TBD_DET_POS     = 3'h1,
		TBD_DET_NEG     = 3'h2,
		TBD_DET_NORMAL  = 3'h3,
		TBD_DET_AVERAGE = 3'h4
	} tbd_det_mode_t;

	typedef enum logic [1:0]
	{
		TBD_AVG_POWER   = 2'h0,
		TBD_AVG_VOLTAGE = 2'h1,
		TBD_AVG_LOG     = 2'h2
	} tbd_avg_type_t;

	typedef struct packed
	{
		logic [TBD_SAMPLE_W-1:0] lin;
		logic [TBD_SAMPLE_W-1:0] db;
	} tbd_sample_t;

	typedef struct packed
	{
		tbd_det_mode_t          mode;
		tbd_avg_type_t          avg_type;
		logic [TBD_POINT_W-1:0] points;
		logic [TBD_CNT_W-1:0]   bucket_len;
	} tbd_cfg_t;

	typedef struct packed
	{
		logic [TBD_POINT_W-1:0]    index;
		logic [TBD_SAMPLE_W-1:0]   value;
		logic [2*TBD_SAMPLE_W-1:0] power;
	} tbd_result_t;

endpackage

/* File: tbd_divider.sv */
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/10ps
module tbd_divider #(
	parameter int unsigned NUM_W = 48,
	parameter int unsigned DEN_W = 16
) (
	input  wire logic             clk_sys_i,
	input  wire logic             arst_n_i,
	input  wire logic             start_i,
	input  wire logic [NUM_W-1:0] num_i,
	input  wire logic [DEN_W-1:0] den_i,
	output logic                  done_o,
	output logic      [NUM_W-1:0] quo_o
);
	initial
	begin
		if (NUM_W < 2 || DEN_W < 1 || NUM_W > 255)
			$error("tbd_divider: unsupported widths");
	end

	logic [DEN_W:0]   rem_r,  rem_nxt;
	logic [NUM_W-1:0] quo_r,  quo_nxt;
	logic [DEN_W-1:0] den_r,  den_nxt;
	logic [7:0]       cnt_r,  cnt_nxt;
	logic             busy_r, busy_nxt;
	logic             done_r, done_nxt;

	always_comb
	begin
		logic [DEN_W:0] shifted;
		shifted  = {rem_r[DEN_W-1:0], quo_r[NUM_W-1]};
		rem_nxt  = rem_r;
		quo_nxt  = quo_r;
		den_nxt  = den_r;
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start_i)
		begin
			rem_nxt  = '0;
			quo_nxt  = num_i;
			den_nxt  = den_i;
			cnt_nxt  = 8'h00;
			busy_nxt = 1'b1;
		end
		else if (busy_r)
		begin
			if (shifted >= {1'b0, den_r})
			begin
				rem_nxt = shifted - {1'b0, den_r};
				quo_nxt = {quo_r[NUM_W-2:0], 1'b1};
			end
			else
			begin
				rem_nxt = shifted;
				quo_nxt = {quo_r[NUM_W-2:0], 1'b0};
			end
			cnt_nxt = cnt_r + 8'h01;
			if (cnt_r == 8'(NUM_W - 1))
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rem_r  <= '0;
			quo_r  <= '0;
			den_r  <= '0;
			cnt_r  <= 8'h00;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			rem_r  <= rem_nxt;
			quo_r  <= quo_nxt;
			den_r  <= den_nxt;
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_o = done_r;
	assign quo_o  = quo_r;
endmodule

/* File: tbd_isqrt.sv */
// Sequential integer square root, one root bit per clock.
`timescale 1ns/10ps
module tbd_isqrt #(
	parameter int unsigned ROOT_W = 16
) (
	input  wire logic                clk_sys_i,
	input  wire logic                arst_n_i,
	input  wire logic                start_i,
	input  wire logic [2*ROOT_W-1:0] rad_i,
	output logic                     done_o,
	output logic      [ROOT_W-1:0]   root_o
);
	initial
	begin
		if (ROOT_W < 2 || ROOT_W > 127)
			$error("tbd_isqrt: unsupported width");
	end

	logic [2*ROOT_W-1:0] rad_r,  rad_nxt;
	logic [ROOT_W+1:0]   rem_r,  rem_nxt;
	logic [ROOT_W-1:0]   root_r, root_nxt;
	logic [7:0]          cnt_r,  cnt_nxt;
	logic                busy_r, busy_nxt;
	logic                done_r, done_nxt;

	always_comb
	begin
		logic [ROOT_W+1:0] acc;
		logic [ROOT_W+1:0] trial;
		acc      = {rem_r[ROOT_W-1:0], rad_r[2*ROOT_W-1 -: 2]};
		trial    = {root_r, 2'b01};
		rad_nxt  = rad_r;
		rem_nxt  = rem_r;
		root_nxt = root_r;
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start_i)
		begin
			rad_nxt  = rad_i;
			rem_nxt  = '0;
			root_nxt = '0;
			cnt_nxt  = 8'h00;
			busy_nxt = 1'b1;
		end
		else if (busy_r)
		begin
			rad_nxt = {rad_r[2*ROOT_W-3:0], 2'b00};
			if (acc >= trial)
			begin
				rem_nxt  = acc - trial;
				root_nxt = {root_r[ROOT_W-2:0], 1'b1};
			end
			else
			begin
				rem_nxt  = acc;
				root_nxt = {root_r[ROOT_W-2:0], 1'b0};
			end
			cnt_nxt = cnt_r + 8'h01;
			if (cnt_r == 8'(ROOT_W - 1))
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rad_r  <= '0;
			rem_r  <= '0;
			root_r <= '0;
			cnt_r  <= 8'h00;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			rad_r  <= rad_nxt;
			rem_r  <= rem_nxt;
			root_r <= root_nxt;
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_o = done_r;
	assign root_o = root_r;
endmodule

/* File: tbd_detector.sv */
// Trace bucket detector: reduces envelope samples to one result per trace point.
`timescale 1ns/10ps
module tbd_detector #(
	parameter int unsigned MAX_POINTS = 40001
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 arst_n_i,
	input  wire logic                 sweep_start_i,
	input  wire tbd_pkg::tbd_cfg_t    cfg_i,
	input  wire logic                 smp_valid_i,
	input  wire tbd_pkg::tbd_sample_t smp_i,
	output logic                      smp_ready_o,
	output logic                      res_valid_o,
	output tbd_pkg::tbd_result_t      res_o,
	output logic                      sweep_done_o,
	output logic                      sweeping_o
);
	import tbd_pkg::*;

	initial
	begin
		if (MAX_POINTS < TBD_MIN_POINTS || MAX_POINTS > TBD_MAX_POINTS)
			$error("tbd_detector: MAX_POINTS out of range");
	end

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'b00001,
		ST_RUN  = 5'b00010,
		ST_MEAN = 5'b00100,
		ST_ROOT = 5'b01000,
		ST_PWR  = 5'b10000
	} tbd_state_t;

	localparam logic [TBD_POINT_W-1:0] MAX_PTS = TBD_POINT_W'(MAX_POINTS);

	tbd_state_t                 state_r,     state_nxt;
	tbd_cfg_t                   cfg_r,       cfg_nxt;
	logic [TBD_POINT_W-1:0]     points_r,    points_nxt;
	logic [TBD_POINT_W-1:0]     bkt_r,       bkt_nxt;
	logic [TBD_CNT_W-1:0]       cnt_r,       cnt_nxt;
	logic [TBD_SAMPLE_W-1:0]    max_r,       max_nxt;
	logic [TBD_SAMPLE_W-1:0]    min_r,       min_nxt;
	logic [TBD_SAMPLE_W-1:0]    prev_r,      prev_nxt;
	logic [TBD_SAMPLE_W-1:0]    mid_r,       mid_nxt;
	logic [TBD_SAMPLE_W-1:0]    stored_r,    stored_nxt;
	logic [TBD_SAMPLE_W-1:0]    rms_r,       rms_nxt;
	logic                       rose_r,      rose_nxt;
	logic                       fell_r,      fell_nxt;
	logic [TBD_ACC_W-1:0]       acc_r,       acc_nxt;
	logic [2*TBD_SAMPLE_W-1:0]  mean_r,      mean_nxt;
	tbd_result_t                res_r,       res_nxt;
	logic                       res_valid_r, res_valid_nxt;
	logic                       ready_r,     ready_nxt;
	logic                       done_r,      done_nxt;
	logic                       sweeping_r,  sweeping_nxt;
	logic                       div_start;
	logic [TBD_ACC_W-1:0]       div_num;
	logic [TBD_CNT_W-1:0]       div_den;
	logic                       div_done;
	logic [TBD_ACC_W-1:0]       div_quo;
	logic                       sqrt_start;
	logic                       sqrt_done;
	logic [TBD_SAMPLE_W-1:0]    sqrt_root;

	tbd_divider #(
		.NUM_W (TBD_ACC_W),
		.DEN_W (TBD_CNT_W)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.start_i   (div_start),
		.num_i     (div_num),
		.den_i     (div_den),
		.done_o    (div_done),
		.quo_o     (div_quo)
	);

	tbd_isqrt #(
		.ROOT_W (TBD_SAMPLE_W)
	) u_sqrt (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.start_i   (sqrt_start),
		.rad_i     (mean_nxt),
		.done_o    (sqrt_done),
		.root_o    (sqrt_root)
	);

	always_comb
	begin
		logic [TBD_CNT_W-1:0]      blen;
		logic                      is_avg;
		logic                      is_pwr;
		logic [TBD_SAMPLE_W-1:0]   v;
		logic                      take;
		logic                      first;
		logic                      last;
		logic                      noise;
		logic [TBD_SAMPLE_W-1:0]   max_c;
		logic [TBD_SAMPLE_W-1:0]   min_c;
		logic [TBD_SAMPLE_W-1:0]   mid_c;
		logic [TBD_ACC_W-1:0]      term;
		logic [TBD_ACC_W-1:0]      acc_c;
		logic [2*TBD_SAMPLE_W-1:0] sq;
		logic                      emit;
		logic [TBD_SAMPLE_W-1:0]   emit_val;
		logic [2*TBD_SAMPLE_W-1:0] emit_pwr;
		blen     = (cfg_r.bucket_len == '0) ? TBD_CNT_W'(1) : cfg_r.bucket_len;
		is_avg   = (cfg_r.mode == TBD_DET_AVERAGE);
		is_pwr   = is_avg && (cfg_r.avg_type == TBD_AVG_POWER);
		// Log averaging works on the decibel-scaled sample, all else on linear volts.
		v        = (is_avg && cfg_r.avg_type == TBD_AVG_LOG) ? smp_i.db : smp_i.lin;
		take     = (state_r == ST_RUN) && smp_valid_i && ready_r;
		first    = (cnt_r == '0);
		last     = (cnt_r == blen - TBD_CNT_W'(1));
		max_c    = (first || v > max_r) ? v : max_r;
		min_c    = (first || v < min_r) ? v : min_r;
		mid_c    = (cnt_r == (blen >> 1)) ? v : mid_r;
		sq       = v * v;
		term     = is_pwr ? TBD_ACC_W'(sq) : TBD_ACC_W'(v);
		acc_c    = first ? term : acc_r + term;
		noise    = (rose_r || (!first && v > prev_r)) && (fell_r || (!first && v < prev_r));
		emit     = 1'b0;
		emit_val = TBD_LOWEST_AMP;
		emit_pwr = '0;
		div_start  = 1'b0;
		div_num    = acc_c;
		div_den    = blen;
		sqrt_start = 1'b0;

		state_nxt     = state_r;
		cfg_nxt       = cfg_r;
		points_nxt    = points_r;
		bkt_nxt       = bkt_r;
		cnt_nxt       = cnt_r;
		max_nxt       = max_r;
		min_nxt       = min_r;
		prev_nxt      = prev_r;
		mid_nxt       = mid_r;
		stored_nxt    = stored_r;
		rms_nxt       = rms_r;
		rose_nxt      = rose_r;
		fell_nxt      = fell_r;
		acc_nxt       = acc_r;
		mean_nxt      = mean_r;
		res_nxt       = res_r;
		res_valid_nxt = 1'b0;
		done_nxt      = 1'b0;

		case (state_r)
			ST_RUN:
			begin
				if (take)
				begin
					max_nxt  = max_c;
					min_nxt  = min_c;
					mid_nxt  = mid_c;
					acc_nxt  = acc_c;
					prev_nxt = v;
					rose_nxt = !first && (rose_r || v > prev_r);
					fell_nxt = !first && (fell_r || v < prev_r);
					cnt_nxt  = last ? '0 : cnt_r + TBD_CNT_W'(1);
					if (last && is_avg)
					begin
						// Average modes stall the source while the arithmetic runs.
						div_start = 1'b1;
						state_nxt = ST_MEAN;
					end
					else if (last)
					begin
						emit = 1'b1;
						case (cfg_r.mode)
							TBD_DET_SAMPLE:
								emit_val = mid_c;
							TBD_DET_POS:
								emit_val = max_c;
							TBD_DET_NEG:
								emit_val = min_c;
							default:
							begin
								if (noise && bkt_r[0])
									emit_val = (max_c > stored_r) ? max_c : stored_r;
								else if (noise)
									emit_val = min_c;
								else
									emit_val = max_c;
								// Only an even noise bucket hands its peak on to the next one.
								stored_nxt = (noise && !bkt_r[0]) ? max_c : TBD_LOWEST_AMP;
							end
						endcase
					end
				end
			end
			ST_MEAN:
			begin
				if (div_done && is_pwr)
				begin
					mean_nxt   = div_quo[2*TBD_SAMPLE_W-1:0];
					sqrt_start = 1'b1;
					state_nxt  = ST_ROOT;
				end
				else if (div_done)
				begin
					emit     = 1'b1;
					emit_val = div_quo[TBD_SAMPLE_W-1:0];
				end
			end
			ST_ROOT:
			begin
				if (sqrt_done)
				begin
					rms_nxt   = sqrt_root;
					div_start = 1'b1;
					div_num   = TBD_ACC_W'(mean_r);
					div_den   = TBD_IMPEDANCE_OHM;
					state_nxt = ST_PWR;
				end
			end
			ST_PWR:
			begin
				if (div_done)
				begin
					emit     = 1'b1;
					emit_val = rms_r;
					emit_pwr = div_quo[2*TBD_SAMPLE_W-1:0];
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase

		if (emit)
		begin
			res_nxt       = '{index: bkt_r, value: emit_val, power: emit_pwr};
			res_valid_nxt = 1'b1;
			if (bkt_r >= points_r)
			begin
				state_nxt = ST_IDLE;
				done_nxt  = 1'b1;
			end
			else
			begin
				bkt_nxt   = bkt_r + TBD_POINT_W'(1);
				state_nxt = ST_RUN;
			end
		end

		// A restart abandons any bucket in progress, including pending arithmetic.
		if (sweep_start_i)
		begin
			cfg_nxt       = cfg_i;
			points_nxt    = (cfg_i.points == '0) ? TBD_POINT_W'(TBD_MIN_POINTS)
			                : (cfg_i.points > MAX_PTS) ? MAX_PTS : cfg_i.points;
			bkt_nxt       = TBD_FIRST_BUCKET;
			stored_nxt    = TBD_LOWEST_AMP;
			cnt_nxt       = '0;
			rose_nxt      = 1'b0;
			fell_nxt      = 1'b0;
			// A dropped result must not disturb the value held on the result port.
			res_nxt       = res_r;
			res_valid_nxt = 1'b0;
			done_nxt      = 1'b0;
			state_nxt     = ST_RUN;
		end
		ready_nxt = (state_nxt == ST_RUN);
		sweeping_nxt = (state_nxt != ST_IDLE);
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_r     <= ST_IDLE;
			cfg_r       <= '{mode: TBD_DET_SAMPLE, avg_type: TBD_AVG_POWER, points: '0, bucket_len: '0};
			points_r    <= TBD_POINT_W'(TBD_MIN_POINTS);
			bkt_r       <= TBD_FIRST_BUCKET;
			cnt_r       <= '0;
			max_r       <= TBD_LOWEST_AMP;
			min_r       <= TBD_LOWEST_AMP;
			prev_r      <= TBD_LOWEST_AMP;
			mid_r       <= TBD_LOWEST_AMP;
			stored_r    <= TBD_LOWEST_AMP;
			rms_r       <= TBD_LOWEST_AMP;
			rose_r      <= 1'b0;
			fell_r      <= 1'b0;
			acc_r       <= '0;
			mean_r      <= '0;
			res_r       <= '0;
			res_valid_r <= 1'b0;
			ready_r     <= 1'b0;
			done_r      <= 1'b0;
			sweeping_r  <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			cfg_r       <= cfg_nxt;
			points_r    <= points_nxt;
			bkt_r       <= bkt_nxt;
			cnt_r       <= cnt_nxt;
			max_r       <= max_nxt;
			min_r       <= min_nxt;
			prev_r      <= prev_nxt;
			mid_r       <= mid_nxt;
			stored_r    <= stored_nxt;
			rms_r       <= rms_nxt;
			rose_r      <= rose_nxt;
			fell_r      <= fell_nxt;
			acc_r       <= acc_nxt;
			mean_r      <= mean_nxt;
			res_r       <= res_nxt;
			res_valid_r <= res_valid_nxt;
			ready_r     <= ready_nxt;
			done_r      <= done_nxt;
			sweeping_r  <= sweeping_nxt;
		end
	end

	assign smp_ready_o  = ready_r;
	assign res_valid_o  = res_valid_r;
	assign res_o        = res_r;
	assign sweep_done_o = done_r;
	assign sweeping_o   = sweeping_r;
endmodule

/* File: tbd_detector_assertions.sv */
// Port checker for the trace bucket detector, bound to its top module.
`timescale 1ns/10ps
module tbd_detector_assertions
	import tbd_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        arst_n_i,
	input wire logic        sweep_start_i,
	input wire tbd_cfg_t    cfg_i,
	input wire logic        smp_valid_i,
	input wire tbd_sample_t smp_i,
	input wire logic        smp_ready_o,
	input wire logic        res_valid_o,
	input wire tbd_result_t res_o,
	input wire logic        sweep_done_o,
	input wire logic        sweeping_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	logic          first_r;
	logic [15:0]   idx_r;
	logic [15:0]   lin_r;
	tbd_det_mode_t mode_r;

	// The last taken sample is the bucket's last one when a peak result appears.
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			first_r <= 1'b0;
			idx_r   <= 16'h0000;
			lin_r   <= 16'h0000;
			mode_r  <= TBD_DET_SAMPLE;
		end
		else
		begin
			if (sweep_start_i)
			begin
				first_r <= 1'b1;
				mode_r  <= cfg_i.mode;
			end
			else if (res_valid_o)
				first_r <= 1'b0;
			if (res_valid_o)
				idx_r <= res_o.index;
			if (smp_valid_i && smp_ready_o)
				lin_r <= smp_i.lin;
		end
	end

	property p_first_index;
		res_valid_o && first_r |-> res_o.index == 16'h0001;
	endproperty
	a_first_index: assert property (p_first_index) else $error("first bucket index is not one");
	property p_index_step;
		res_valid_o && !first_r |-> res_o.index == idx_r + 16'h0001;
	endproperty
	a_index_step: assert property (p_index_step) else $error("bucket index did not step by one");
	property p_done_with_res;
		sweep_done_o |-> res_valid_o;
	endproperty
	a_done_with_res: assert property (p_done_with_res) else $error("sweep done without a result");
	property p_ready_after_start;
		sweep_start_i |=> smp_ready_o && sweeping_o;
	endproperty
	a_ready_after_start: assert property (p_ready_after_start) else $error("no ready after sweep start");
	property p_done_stops;
		sweep_done_o && !sweep_start_i |=> !smp_ready_o && !sweeping_o;
	endproperty
	a_done_stops: assert property (p_done_stops) else $error("sweep kept running after its last bucket");
	property p_res_hold;
		!res_valid_o |-> $stable(res_o);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result changed without a strobe");
	property p_pos_max;
		res_valid_o && mode_r == TBD_DET_POS |-> res_o.value >= lin_r;
	endproperty
	a_pos_max: assert property (p_pos_max) else $error("peak result below a bucket sample");
	property p_neg_min;
		res_valid_o && mode_r == TBD_DET_NEG |-> res_o.value <= lin_r;
	endproperty
	a_neg_min: assert property (p_neg_min) else $error("minimum result above a bucket sample");
	property p_avg_ready;
		res_valid_o && !sweep_done_o && mode_r == TBD_DET_AVERAGE |-> smp_ready_o;
	endproperty
	a_avg_ready: assert property (p_avg_ready) else $error("average result without ready");
endmodule

bind tbd_detector tbd_detector_assertions i_chk (
	.clk_sys_i    (clk_sys_i),
	.arst_n_i     (arst_n_i),
	.sweep_start_i(sweep_start_i),
	.cfg_i        (cfg_i),
	.smp_valid_i  (smp_valid_i),
	.smp_i        (smp_i),
	.smp_ready_o  (smp_ready_o),
	.res_valid_o  (res_valid_o),
	.res_o        (res_o),
	.sweep_done_o (sweep_done_o),
	.sweeping_o   (sweeping_o)
);

/* File: tbd_source_model.sv */
// Envelope sample source and trace memory facing the detector.
`timescale 1ns/10ps
module tbd_source_model
	import tbd_pkg::*;
(
	input wire logic         clk_sys_i,
	input wire logic         arst_n_i,
	input wire logic         smp_ready_i,
	input wire logic         res_valid_i,
	input wire tbd_result_t  res_i,
	output logic             smp_valid_o,
	output tbd_sample_t      smp_o
);
	tbd_sample_t smp_q[$];
	tbd_result_t res_q[$];
	bit          slow = 1'b0;

	// Idle data is inverted so a stale sample can never pass for a fresh one.
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			smp_valid_o <= 1'b0;
			smp_o       <= '1;
		end
		else if (!smp_valid_o || smp_ready_i)
		begin
			if (smp_q.size() > 0 && !(slow && $urandom % 3 == 0))
			begin
				smp_valid_o <= 1'b1;
				smp_o       <= smp_q.pop_front();
			end
			else
			begin
				smp_valid_o <= 1'b0;
				smp_o       <= ~smp_o;
			end
		end
	end

	always @(posedge clk_sys_i)
	begin
		if (res_valid_i === 1'b1)
			res_q.push_back(res_i);
	end
endmodule

/* File: tbd_detector_tb.sv */
// Self-checking testbench for the trace bucket detector.
`timescale 1ns/10ps
module tbd_detector_tb;
	import tbd_pkg::*;
	logic        clk_sys_i;
	logic        arst_n_i;
	logic        sweep_start_i;
	tbd_cfg_t    cfg_i;
	logic        smp_valid_i;
	tbd_sample_t smp_i;
	logic        smp_ready_o;
	logic        res_valid_o;
	tbd_result_t res_o;
	logic        sweep_done_o;
	logic        sweeping_o;
	int          errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          dones = 0;
	logic [15:0] bl[16];
	logic [15:0] bd[16];
	logic [15:0] st;

	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	tbd_detector #(.MAX_POINTS(4)) i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sweep_start_i(sweep_start_i),
		.cfg_i(cfg_i), .smp_valid_i(smp_valid_i), .smp_i(smp_i), .smp_ready_o(smp_ready_o),
		.res_valid_o(res_valid_o), .res_o(res_o), .sweep_done_o(sweep_done_o), .sweeping_o(sweeping_o));
	tbd_source_model i_src (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .smp_ready_i(smp_ready_o),
		.res_valid_i(res_valid_o), .res_i(res_o), .smp_valid_o(smp_valid_i), .smp_o(smp_i));

	task test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (sweep_done_o === 1'b1)
			dones++;
		if (cycles == 20000)
		begin
			errors++;
			$display("CHECK FAILED timeout expected finish seen hang");
			test_done();
		end
	end

	function automatic logic [15:0] isq(input logic [31:0] x);
		logic [31:0] r;
		logic [63:0] t;
		r = '0;
		for (int b = 15; b >= 0; b--)
		begin
			t = r | (32'h1 << b);
			if (t * t <= x)
				r = t[31:0];
		end
		return r[15:0];
	endfunction

	// Normal mode carries the remembered maximum in st from one bucket to the next.
	function automatic logic [63:0] exp_res(tbd_det_mode_t m, tbd_avg_type_t a, int idx, int n);
		logic [47:0] s;
		logic [47:0] q;
		logic [15:0] mx;
		logic [15:0] mn;
		logic [15:0] v;
		logic [31:0] p;
		bit          up;
		bit          dn;
		s  = '0;
		p  = '0;
		up = 0;
		dn = 0;
		mx = bl[0];
		mn = bl[0];
		for (int k = 0; k < n; k++)
		begin
			s += (a == TBD_AVG_POWER) ? bl[k] * bl[k] : ((a == TBD_AVG_LOG) ? bd[k] : bl[k]);
			if (bl[k] > mx)
				mx = bl[k];
			if (bl[k] < mn)
				mn = bl[k];
			if (k > 0 && bl[k] > bl[k-1])
				up = 1;
			if (k > 0 && bl[k] < bl[k-1])
				dn = 1;
		end
		q = s / n;
		case (m)
			TBD_DET_SAMPLE: v = bl[n/2];
			TBD_DET_POS:    v = mx;
			TBD_DET_NEG:    v = mn;
			TBD_DET_NORMAL:
			begin
				v = (up && dn && idx % 2 == 0) ? mn : ((up && dn && mx < st) ? st : mx);
				st = (up && dn && idx % 2 == 0) ? mx : 16'h0000;
			end
			default:
			begin
				v = (a == TBD_AVG_POWER) ? isq(q[31:0]) : q[15:0];
				p = (a == TBD_AVG_POWER) ? 32'(q / 50) : 32'h0;
			end
		endcase
		return {idx[15:0], v, p};
	endfunction

	task automatic run(tbd_det_mode_t m, tbd_avg_type_t a, int pts, int len);
		int          p;
		int          n;
		logic [63:0] eq[$];
		p  = (pts == 0) ? 1 : ((pts > 4) ? 4 : pts);
		n  = (len == 0) ? 1 : len;
		st = 16'h0000;
		@(posedge clk_sys_i);
		sweep_start_i <= 1'b1;
		cfg_i         <= '{m, a, pts[15:0], len[15:0]};
		@(posedge clk_sys_i);
		sweep_start_i <= 1'b0;
		dones = 0;
		for (int b = 1; b <= p; b++)
		begin
			for (int k = 0; k < n; k++)
			begin
				bl[k] = (m == TBD_DET_NORMAL && b == 4) ? 16'(k * 256) : 16'($urandom);
				if (m == TBD_DET_NORMAL && b == 3)
					bl[k] = 16'($urandom % 256);
				bd[k] = 16'($urandom);
				i_src.smp_q.push_back({bl[k], bd[k]});
			end
			eq.push_back(exp_res(m, a, b, n));
		end
		for (int w = 0; w < 2000 && i_src.res_q.size() < p; w++)
			@(negedge clk_sys_i);
		repeat (3) @(negedge clk_sys_i);
		cmp("result_count", p, i_src.res_q.size());
		cmp("stopped", 0, {sweeping_o, smp_ready_o});
		cmp("sweep_done", 1, dones);
		while (eq.size() > 0 && i_src.res_q.size() > 0)
			cmp("bucket", eq.pop_front(), i_src.res_q.pop_front());
		i_src.res_q.delete();
	endtask

	initial
	begin
		arst_n_i      = 1'b0;
		sweep_start_i = 1'b0;
		cfg_i         = '0;
		void'($urandom(32'hF2FD0566));
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(negedge clk_sys_i);
		cmp("idle", 0, {sweeping_o, smp_ready_o, res_valid_o});
		run(TBD_DET_SAMPLE, TBD_AVG_POWER, 4, 5);
		run(TBD_DET_POS, TBD_AVG_POWER, 9, 4);
		run(TBD_DET_NEG, TBD_AVG_POWER, 0, 3);
		run(TBD_DET_NORMAL, TBD_AVG_POWER, 4, 4);
		run(TBD_DET_NORMAL, TBD_AVG_POWER, 4, 4);
		run(TBD_DET_POS, TBD_AVG_POWER, 4, 1);
		i_src.slow = 1'b1;
		for (int a = 0; a < 3; a++)
			run(TBD_DET_AVERAGE, tbd_avg_type_t'(a), 4, (a == 1) ? 1 : 4);
		run(TBD_DET_NORMAL, TBD_AVG_POWER, 4, 2);
		test_done();
	end
endmodule
